// *** verilog/e1as_params.svh ***
// Offsets, field positions, reset values and timing counts of the E1 receive alarm monitor
`ifndef E1AS_PARAMS_SVH
`define E1AS_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define E1AS_OFS_RX_SIG 5'h18
`define E1AS_OFS_ALARM1 5'h19
`define E1AS_OFS_SA6 5'h1a
`define E1AS_OFS_ID 5'h1f
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define E1AS_SA5_BIT 7
`define E1AS_SA6_HI 6
`define E1AS_SA6_LO 3
`define E1AS_ATT_SHORT 2'h0
`define E1AS_ATT_MEDIUM 2'h1
// Arbitrary identification value
`define E1AS_DEV_CODE 8'h5c
`define E1AS_RDATA_RST 8'h00
// ----------------------------------------
// Timing and counts
// ----------------------------------------
`define E1AS_CLK_MHZ 40
`define E1AS_LINE_SIGNAL_LOST_TIME_US 1000
`define E1AS_LINE_SIGNAL_LOST_CYCLES (`E1AS_LINE_SIGNAL_LOST_TIME_US * `E1AS_CLK_MHZ)
`define E1AS_LOS_BITS 7'h7f
`define E1AS_LOS_ONES 7'h10
`define E1AS_EBIT_LIMIT 10'h3dd
`define E1AS_FAIL_SECS 3'h5
`define E1AS_SA6_SAME 3'h7
`define E1AS_AIS_WIN_SHORT 12'h1ff
`define E1AS_AIS_WIN_LONG 12'hfff
`define E1AS_AIS_ZEROS 2'h3
`endif

// *** verilog/e1as_pkg.sv ***
// Types of the E1 receive alarm monitor
package e1as_pkg;
   // Digital loss-of-signal states
   typedef enum logic [2:0] {
      LOS_CLEAR = 3'b001,
      LOS_LOST = 3'b010,
      LOS_PROBE = 3'b100
   } e1as_los_e;

   // Host port request
   typedef struct packed {
      logic cs;
      logic rd;
      logic [4:0] addr;
   } e1as_host_s;

   // Line interface levels
   typedef struct packed {
      logic [1:0] atten;
      logic low_amp;
   } e1as_line_s;

   // Framer events and fields
   typedef struct packed {
      logic bit_en;
      logic bit_val;
      logic frame;
      logic [7:0] ts16;
      logic nfas;
      logic a_bit;
      logic smf1;
      logic smf2;
      logic crc_err;
      logic mf;
      logic crc_cont;
      logic nib_valid;
      logic sa5;
      logic [3:0] sa6;
      logic sec_tick;
      logic ebit_err;
      logic sync_lost;
   } e1as_rx_s;
endpackage : e1as_pkg

// *** verilog/e1as_monitor.sv ***
// E1 receive status and alarm monitor with host status words
// Function
// RL1: Exactly one of long, medium or short loop flags follows the line attenuation class.
// RL2: Line signal lost sets after low amplitude lasts at least 1 ms and is zero otherwise.
// RL3: The first CRC flag takes each submultiframe 1 check result.
// RL4: The second CRC flag takes each submultiframe 2 check result.
// RL5: Remote multiframe fail shows five seconds of over 989 E-bit errors, no RAI, sync kept.
// RL6: Digital loss of signal sets after 127 consecutive zero bits.
// RL7: Loss of signal ends when 127 positions starting with a one hold at least 12.5% ones.
// RL8: Slot 16 all-ones status is updated every frame.
// RL9: The AIS status shows an all-ones signal under the selected criterion.
// RL10: Remote alarm status takes the A bit on each non-alignment frame.
// RL11: The RAI with continuous CRC status is updated once per multiframe.
// RL12: The stable Sa6 flag sets on the eighth consecutive identical nibble.
// RL13: Stable Sa6 captures Sa5 and the nibble, and a read clears the whole word.
// RL14: The changed Sa6 flag sets whenever the nibble differs from the last one.
// RL15: The remote alarm comes from the A bit, one meaning alarm.
// RL16: Status words other than the Sa6 word are read-only with unused bits zero.
`timescale 1ns/100ps
`include "e1as_params.svh"
module e1as_monitor
   import e1as_pkg::*;
#(
   parameter int LINE_SIGNAL_LOST_CYCLES = `E1AS_LINE_SIGNAL_LOST_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Host port
   input wire e1as_host_s host,
   output logic [7:0] rdata,
   output logic rack,
   // Line and framer side
   input wire e1as_line_s line,
   input wire e1as_rx_s rx,
   input wire logic ais_criterion_select
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] rdata;
      logic rack;
      logic long_loop_flag;
      logic medium_loop_flag;
      logic short_loop_flag;
      logic line_signal_lost;
      logic [16:0] amp_cnt;
      logic crc_sub1_error;
      logic crc_sub2_error;
      logic remote_multiframe_fail;
      logic [9:0] ebit_cnt;
      logic sec_rai;
      logic sec_sync;
      logic [2:0] sec_cnt;
      e1as_los_e los_st;
      logic [6:0] zero_cnt;
      logic [6:0] win_cnt;
      logic [6:0] ones_cnt;
      logic [11:0] ais_win;
      logic [1:0] ais_zeros;
      logic all_ones_alarm;
      logic slot16_all_ones;
      logic remote_alarm_status;
      logic remote_alarm_crc_combo;
      logic sa5_cap;
      logic [3:0] sa6_cap;
      logic sa6_stable_flag;
      logic sa6_changed_flag;
      logic [3:0] prev_nib;
      logic nib_seen;
      logic [2:0] same_cnt;
   } e1as_state_s;

   e1as_state_s st_reg;
   e1as_state_s st_next;
   logic los_flag;
   logic rd_sa6;
   logic [11:0] ais_end;

   assign los_flag = (st_reg.los_st != LOS_CLEAR);
   assign rd_sa6 = host.cs && host.rd && (host.addr == `E1AS_OFS_SA6);
   assign ais_end = ais_criterion_select ? `E1AS_AIS_WIN_LONG : `E1AS_AIS_WIN_SHORT;

   // Read multiplexer, used for the read data only; rd_sa6 makes the clear decision
   function automatic logic [7:0] e1as_read(input e1as_state_s s, input logic [4:0] a,
                                            input logic los);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         `E1AS_OFS_RX_SIG: v = {s.long_loop_flag, s.medium_loop_flag, s.short_loop_flag,
                                s.line_signal_lost, 4'h0};
         `E1AS_OFS_ALARM1: v = {s.crc_sub1_error, s.crc_sub2_error, s.remote_multiframe_fail,
                                los, s.slot16_all_ones, s.all_ones_alarm,
                                s.remote_alarm_status, s.remote_alarm_crc_combo};
         `E1AS_OFS_SA6: v = {s.sa5_cap, s.sa6_cap, 1'b0, s.sa6_stable_flag,
                             s.sa6_changed_flag};
         `E1AS_OFS_ID: v = `E1AS_DEV_CODE;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : e1as_read

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.rack = 1'b0;
      // RL16 read-only words
      if (host.cs && host.rd) begin
         st_next.rdata = e1as_read(st_reg, host.addr, los_flag);
         st_next.rack = 1'b1;
      end

      // RL1 one-hot loop class
      st_next.short_loop_flag = (line.atten == `E1AS_ATT_SHORT);
      st_next.medium_loop_flag = (line.atten == `E1AS_ATT_MEDIUM);
      st_next.long_loop_flag = !st_next.short_loop_flag && !st_next.medium_loop_flag;

      // RL2 low amplitude timer
      if (!line.low_amp) begin
         st_next.amp_cnt = 17'h00000;
         st_next.line_signal_lost = 1'b0;
      end else if (st_reg.amp_cnt >= 17'(LINE_SIGNAL_LOST_CYCLES - 1)) begin
         st_next.line_signal_lost = 1'b1;
      end else begin
         st_next.amp_cnt = st_reg.amp_cnt + 17'h00001;
      end

      // RL3 submultiframe 1 result
      if (rx.smf1) begin
         st_next.crc_sub1_error = rx.crc_err;
      end
      // RL4 submultiframe 2 result
      if (rx.smf2) begin
         st_next.crc_sub2_error = rx.crc_err;
      end

      // RL5 per-second E-bit evaluation
      if (rx.ebit_err && st_reg.ebit_cnt != 10'h3ff) begin
         st_next.ebit_cnt = st_reg.ebit_cnt + 10'h001;
      end
      if (rx.nfas && rx.a_bit) begin
         st_next.sec_rai = 1'b1;
      end
      if (rx.sync_lost) begin
         st_next.sec_sync = 1'b1;
      end
      if (rx.sec_tick) begin
         if (st_next.ebit_cnt > `E1AS_EBIT_LIMIT && !st_next.sec_rai && !st_next.sec_sync) begin
            if (st_reg.sec_cnt != `E1AS_FAIL_SECS) begin
               st_next.sec_cnt = st_reg.sec_cnt + 3'h1;
            end
         end else begin
            st_next.sec_cnt = 3'h0;
         end
         st_next.remote_multiframe_fail = (st_next.sec_cnt == `E1AS_FAIL_SECS);
         st_next.ebit_cnt = 10'h000;
         st_next.sec_rai = 1'b0;
         st_next.sec_sync = 1'b0;
      end

      // Digital loss of signal
      if (rx.bit_en) begin
         if (rx.bit_val) begin
            st_next.zero_cnt = 7'h00;
         end else if (st_reg.zero_cnt != `E1AS_LOS_BITS) begin
            st_next.zero_cnt = st_reg.zero_cnt + 7'h01;
         end
         unique case (st_reg.los_st)
            LOS_CLEAR: begin
               // RL6 127 zeros in a row
               if (!rx.bit_val && st_reg.zero_cnt == `E1AS_LOS_BITS - 7'h01) begin
                  st_next.los_st = LOS_LOST;
               end
            end
            LOS_LOST: begin
               // RL7 window opens on a pulse
               if (rx.bit_val) begin
                  st_next.los_st = LOS_PROBE;
                  st_next.win_cnt = 7'h01;
                  st_next.ones_cnt = 7'h01;
               end
            end
            LOS_PROBE: begin
               st_next.win_cnt = st_reg.win_cnt + 7'h01;
               st_next.ones_cnt = st_reg.ones_cnt + {6'h00, rx.bit_val};
               // RL7 density check at window end
               if (st_next.win_cnt == `E1AS_LOS_BITS) begin
                  st_next.los_st = (st_next.ones_cnt >= `E1AS_LOS_ONES) ? LOS_CLEAR : LOS_LOST;
               end
            end
         endcase

         // RL9 zeros per window under the selected length
         if (!rx.bit_val && st_reg.ais_zeros != `E1AS_AIS_ZEROS) begin
            st_next.ais_zeros = st_reg.ais_zeros + 2'h1;
         end
         st_next.ais_win = st_reg.ais_win + 12'h001;
         if (st_reg.ais_win >= ais_end) begin
            st_next.all_ones_alarm = (st_next.ais_zeros < `E1AS_AIS_ZEROS);
            st_next.ais_win = 12'h000;
            st_next.ais_zeros = 2'h0;
         end
      end

      // RL8 slot 16 per frame
      if (rx.frame) begin
         st_next.slot16_all_ones = (rx.ts16 == 8'hff);
      end
      // RL10 RL15 A bit of the non-alignment word
      if (rx.nfas) begin
         st_next.remote_alarm_status = rx.a_bit;
      end
      // RL11 per multiframe
      if (rx.mf) begin
         st_next.remote_alarm_crc_combo = st_next.remote_alarm_status && rx.crc_cont;
      end

      // RL13 read clears, new events below win
      if (rd_sa6) begin
         st_next.sa5_cap = 1'b0;
         st_next.sa6_cap = 4'h0;
         st_next.sa6_stable_flag = 1'b0;
         st_next.sa6_changed_flag = 1'b0;
      end
      if (rx.nib_valid) begin
         st_next.prev_nib = rx.sa6;
         st_next.nib_seen = 1'b1;
         if (st_reg.nib_seen && rx.sa6 != st_reg.prev_nib) begin
            // RL14 nibble changed
            st_next.sa6_changed_flag = 1'b1;
            st_next.same_cnt = 3'h0;
         end else if (!st_reg.nib_seen) begin
            // First nibble starts the run at zero
            st_next.same_cnt = 3'h0;
         end else if (st_reg.same_cnt != `E1AS_SA6_SAME) begin
            st_next.same_cnt = st_reg.same_cnt + 3'h1;
            // RL12 RL13 eighth identical nibble
            if (st_next.same_cnt == `E1AS_SA6_SAME) begin
               st_next.sa6_stable_flag = 1'b1;
               st_next.sa5_cap = rx.sa5;
               st_next.sa6_cap = rx.sa6;
            end
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg <= '0;
         st_reg.rdata <= `E1AS_RDATA_RST;
         st_reg.short_loop_flag <= 1'b1;
         st_reg.los_st <= LOS_CLEAR;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;
   assign rack = st_reg.rack;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   loop_one_hot_a: assert property ( // RL1
      $onehot({st_reg.long_loop_flag, st_reg.medium_loop_flag, st_reg.short_loop_flag}))
      else $error("loop flags not one-hot");

   line_signal_lost_low_a: assert property ( // RL2
      !line.low_amp && ce |=> !st_reg.line_signal_lost)
      else $error("line loss without low amplitude");

   crc_one_a: assert property ( // RL3
      ce && rx.smf1 |=> st_reg.crc_sub1_error == $past(rx.crc_err))
      else $error("crc flag one not updated");

   crc_two_a: assert property ( // RL4
      ce && rx.smf2 |=> st_reg.crc_sub2_error == $past(rx.crc_err))
      else $error("crc flag two not updated");

   fail_secs_a: assert property ( // RL5
      ce && rx.sec_tick && rx.sync_lost |=> !st_reg.remote_multiframe_fail)
      else $error("remote fail despite lost alignment");

   los_enter_a: assert property ( // RL6
      ce && rx.bit_en && !rx.bit_val && st_reg.zero_cnt == 7'h7e |=> los_flag)
      else $error("loss of signal missed");

   los_leave_a: assert property ( // RL7
      los_flag ##1 !los_flag |-> $past(st_reg.ones_cnt) + {6'h00, $past(rx.bit_val)} >= 7'h10)
      else $error("loss of signal left too early");

   slot16_a: assert property ( // RL8
      ce && rx.frame |=> st_reg.slot16_all_ones == ($past(rx.ts16) == 8'hff))
      else $error("slot 16 status wrong");

   rai_a: assert property ( // RL10
      ce && rx.nfas |=> st_reg.remote_alarm_status == $past(rx.a_bit))
      else $error("remote alarm not updated");

   sa6_clear_a: assert property ( // RL13
      ce && rd_sa6 && !rx.nib_valid |=> !st_reg.sa6_stable_flag && st_reg.sa6_cap == 4'h0)
      else $error("sa6 word not cleared");

   sa6_change_a: assert property ( // RL14
      ce && rx.nib_valid && st_reg.nib_seen && rx.sa6 != st_reg.prev_nib
      |=> st_reg.sa6_changed_flag)
      else $error("sa6 change missed");
endmodule : e1as_monitor

// *** sim/e1as_far_end.sv ***
// Far-end terminal model driving line levels and framer events
`timescale 1ns/100ps
module e1as_far_end
   import e1as_pkg::*;
(
   // Clock
   input wire logic clk,
   // Line and framer side
   output e1as_line_s line,
   output e1as_rx_s rx
);
   initial begin
      line = '0;
      rx = '0;
   end

   // ----------------------------------------
   // Line levels
   // ----------------------------------------
   task automatic set_line(input logic [1:0] att, input logic low);
      @(posedge clk);
      line <= '{atten: att, low_amp: low};
   endtask : set_line

   // ----------------------------------------
   // Bit stream, period 0 all zero, else a one every period bits
   // ----------------------------------------
   task automatic bits(input int n, input int period);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx.bit_en <= 1'b1;
         rx.bit_val <= (period != 0) && (i % period == 0);
      end
      @(posedge clk);
      rx.bit_en <= 1'b0;
      rx.bit_val <= ~rx.bit_val;
   endtask : bits

   // ----------------------------------------
   // Event pulse, qualifiers cleared and data fields other than crc_cont inverted once released
   // ----------------------------------------
   task automatic ev(input int k, input logic [7:0] v);
      @(posedge clk);
      {rx.smf1, rx.smf2, rx.frame} <= {k == 1, k == 2, k == 3};
      {rx.nfas, rx.mf, rx.nib_valid} <= {k == 4, k == 5, k == 6};
      {rx.crc_err, rx.a_bit, rx.sa5} <= {v[0], v[0], v[4]};
      rx.ts16 <= v;
      rx.sa6 <= v[3:0];
      if (k == 5) begin
         rx.crc_cont <= v[0];
      end
      @(posedge clk);
      {rx.smf1, rx.smf2, rx.frame, rx.nfas, rx.mf, rx.nib_valid} <= 6'h00;
      {rx.crc_err, rx.a_bit, rx.sa5} <= ~{v[0], v[0], v[4]};
      rx.ts16 <= ~v;
      rx.sa6 <= ~v[3:0];
   endtask : ev

   // ----------------------------------------
   // One second of E-bit errors closed by a tick
   // ----------------------------------------
   task automatic second(input int errs, input logic lost);
      @(posedge clk);
      rx.sync_lost <= lost;
      for (int i = 0; i < errs; i++) begin
         @(posedge clk);
         rx.ebit_err <= 1'b1;
      end
      @(posedge clk);
      rx.ebit_err <= 1'b0;
      rx.sec_tick <= 1'b1;
      @(posedge clk);
      rx.sec_tick <= 1'b0;
      rx.sync_lost <= 1'b0;
   endtask : second
endmodule : e1as_far_end

// *** sim/e1_receive_alarm_status_tb.sv ***
// Self-checking bench for the E1 receive alarm monitor
`timescale 1ns/100ps
`include "e1as_params.svh"
module e1_receive_alarm_status_tb import e1as_pkg::*;;
   localparam int LINE_SIGNAL_LOST_N = 20;
   localparam logic [4:0] RXS = `E1AS_OFS_RX_SIG;
   localparam logic [4:0] AL1 = `E1AS_OFS_ALARM1;
   localparam logic [4:0] SA6 = `E1AS_OFS_SA6;
   logic clk;
   logic sys_rst;
   logic ce;
   logic ais_criterion_select;
   e1as_host_s host;
   wire e1as_line_s line;
   wire e1as_rx_s rx;
   wire logic [7:0] rdata;
   wire logic rack;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int ek[10] = '{1, 2, 1, 2, 4, 5, 4, 5, 3, 3};
   logic [7:0] ev_val[10] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01,
      8'hff, 8'hfe};
   logic [7:0] ev_exp[10] = '{8'h80, 8'hc0, 8'h40, 8'h00, 8'h02, 8'h03, 8'h01, 8'h00,
      8'h08, 8'h00};

   e1as_monitor #(.LINE_SIGNAL_LOST_CYCLES(LINE_SIGNAL_LOST_N)) u_e1as_monitor (.clk(clk), .sys_rst(sys_rst),
      .ce(ce), .host(host), .rdata(rdata), .rack(rack), .line(line), .rx(rx),
      .ais_criterion_select(ais_criterion_select));
   e1as_far_end u_e1as_far_end (.clk(clk), .line(line), .rx(rx));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------
   // Compare, host read and closing report
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_read(input logic [4:0] addr, output logic [7:0] data);
      int w;
      @(posedge clk);
      host <= '{cs: 1'b1, rd: 1'b1, addr: addr};
      @(posedge clk);
      host <= '{cs: 1'b0, rd: 1'b0, addr: ~addr};
      w = 0;
      #1;
      while (rack !== 1'b1 && w < 4) begin
         @(posedge clk);
         #1;
         w++;
      end
      data = (rack === 1'b1 && w == 0) ? rdata : 8'hxx;
   endtask : reg_read

   task automatic reg_check(input logic [4:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      reg_read(addr, d);
      check(d, exp);
   endtask : reg_check

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      ais_criterion_select = 1'b0;
      host = '0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      reg_check(RXS, 8'h20);
      reg_check(AL1, 8'h00);
      reg_check(SA6, 8'h00);
      reg_check(`E1AS_OFS_ID, `E1AS_DEV_CODE);
      reg_check(5'h05, 8'h00);
      // Loop classes
      for (int a = 0; a < 4; a++) begin
         u_e1as_far_end.set_line(a[1:0], 1'b0);
         reg_check(RXS, a == 0 ? 8'h20 : a == 1 ? 8'h40 : 8'h80);
      end
      // Line amplitude loss
      u_e1as_far_end.set_line(2'h0, 1'b1);
      repeat (LINE_SIGNAL_LOST_N / 2) @(posedge clk);
      reg_check(RXS, 8'h20);
      repeat (LINE_SIGNAL_LOST_N) @(posedge clk);
      reg_check(RXS, 8'h30);
      u_e1as_far_end.set_line(2'h0, 1'b0);
      reg_check(RXS, 8'h20);
      // CRC, remote alarm, combined and slot 16 events
      for (int i = 0; i < 10; i++) begin
         u_e1as_far_end.ev(ek[i], ev_val[i]);
         reg_check(AL1, ev_exp[i]);
      end
      // Digital loss of signal, exit windows, all-ones
      u_e1as_far_end.bits(126, 0);
      reg_check(AL1, 8'h00);
      u_e1as_far_end.bits(1, 0);
      reg_check(AL1, 8'h10);
      u_e1as_far_end.bits(127, 9);
      reg_check(AL1, 8'h10);
      u_e1as_far_end.bits(127, 8);
      reg_check(AL1, 8'h00);
      u_e1as_far_end.bits(1100, 1);
      reg_check(AL1, 8'h04);
      // Sa6 nibbles
      u_e1as_far_end.ev(6, 8'h1a);
      reg_check(SA6, 8'h00);
      repeat (6) u_e1as_far_end.ev(6, 8'h1a);
      reg_check(SA6, 8'h00);
      u_e1as_far_end.ev(6, 8'h1a);
      reg_check(SA6, 8'hd2);
      reg_check(SA6, 8'h00);
      u_e1as_far_end.ev(6, 8'h15);
      reg_check(SA6, 8'h01);
      // Remote multiframe failure
      u_e1as_far_end.second(989, 1'b0);
      repeat (4) u_e1as_far_end.second(990, 1'b0);
      reg_check(AL1, 8'h04);
      u_e1as_far_end.second(990, 1'b0);
      reg_check(AL1, 8'h24);
      u_e1as_far_end.second(990, 1'b1);
      reg_check(AL1, 8'h04);
      // Frozen while clock enable is low
      @(posedge clk);
      ce <= 1'b0;
      u_e1as_far_end.ev(1, 8'h01);
      ce <= 1'b1;
      reg_check(AL1, 8'h04);
      // Long all-ones window
      @(posedge clk);
      ais_criterion_select <= 1'b1;
      u_e1as_far_end.bits(3, 0);
      u_e1as_far_end.bits(100, 1);
      reg_check(AL1, 8'h04);
      u_e1as_far_end.bits(3600, 1);
      reg_check(AL1, 8'h00);
      wrap_up();
   end
endmodule : e1_receive_alarm_status_tb
